// ===== src/srdio_pkg.sv
// Types shared by the scan-refreshed discrete I/O block
package srdio_pkg;

  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } srdio_wb_t;

  // Whole state of the block
  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] filt;
    logic [15:0][12:0] cnt;
    logic [8:0] tick_cnt;
    logic tick;
    logic [15:0] in_img;
    logic [7:0] out_img;
    logic [7:0] out_pin;
    logic stopped;
    logic err_hold;
    logic [2:0] hs_sel;
    logic [2:0] st_sel;
    logic [15:0] irq_en;
    logic [31:0] trig;
    logic [15:0] stat;
    logic [15:0] pend;
    logic [15:0] mask;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } srdio_st_t;

endpackage

// ===== src/srdio_regs.svh
// Register map, field positions and timing constants of the discrete I/O
`ifndef SRDIO_REGS_SVH
`define SRDIO_REGS_SVH

// Word indices on the bus (byte address is four times the index)
`define SRDIO_W_CMD 6'h00
`define SRDIO_W_CFG 6'h01
`define SRDIO_W_IN_IMG 6'h02
`define SRDIO_W_IN_NOW 6'h03
`define SRDIO_W_IN_RFS 6'h04
`define SRDIO_W_OUT_IMG 6'h05
`define SRDIO_W_OUT_NOW 6'h06
`define SRDIO_W_OUT_RFS 6'h07
`define SRDIO_W_IRQ_EN 6'h08
`define SRDIO_W_TRIG 6'h09
`define SRDIO_W_IRQ_STAT 6'h0a
`define SRDIO_W_IRQ_MASK 6'h0b

// Command register bits
`define SRDIO_B_EOS 0
`define SRDIO_B_STOP 1
`define SRDIO_B_RUN 2
// Config register fields
`define SRDIO_B_HOLD 0
`define SRDIO_F_HS 6:4
`define SRDIO_F_ST 10:8
// Immediate output register: value and lane mask
`define SRDIO_F_ONV 7:0
`define SRDIO_F_ONM 15:8

// Pin counts
`define SRDIO_HS_PINS 6
`define SRDIO_ST_PINS 10
`define SRDIO_N_IN 16
`define SRDIO_N_OUT 8

// Clock and filter tick
`define SRDIO_CLK_NS 25
`define SRDIO_TICK_NS 10000
`define SRDIO_TICK_CYC (`SRDIO_TICK_NS / `SRDIO_CLK_NS)

// Filter settings in microseconds, high-speed group
`define SRDIO_HS_T0 10
`define SRDIO_HS_T1 100
`define SRDIO_HS_T2 200
`define SRDIO_HS_T3 400
`define SRDIO_HS_T4 600
`define SRDIO_HS_T5 1000
// Filter settings in microseconds, standard group
`define SRDIO_ST_T0 100
`define SRDIO_ST_T1 1000
`define SRDIO_ST_T2 5000
`define SRDIO_ST_T3 10000
`define SRDIO_ST_T4 20000
`define SRDIO_ST_T5 70000

`endif

// ===== src/srdio_top.sv
// Scan-refreshed discrete I/O: filtered inputs, outputs, input interrupts
`timescale 1ns/10ps
`default_nettype none
`include "srdio_regs.svh"

// Operation
// RQ1 - Sixteen inputs: six fast, ten standard
// RQ2 - Input image updates only at end-of-scan
// RQ3 - Immediate input read returns live filtered pins
// RQ4 - Partial refresh updates named input image bits
// RQ5 - Standard filter from 0.1 to 70 ms
// RQ6 - Fast filter from 0.01 to 1 ms
// RQ7 - Eight outputs follow output image
// RQ8 - Output pins update only at end-of-scan
// RQ9 - Immediate output write drives pin at once
// RQ10 - Partial refresh copies named output bits
// RQ11 - Program stop holds or clears outputs
// RQ12 - Any input may raise an interrupt
// RQ13 - Trigger on rise, fall or both
// RQ14 - One further trigger pends, later dropped
// RQ15 - Filter accepts level stable for ticks
module srdio_top
  import srdio_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Wishbone slave
  input wire srdio_wb_t i_wb,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Field pins
  input wire logic [15:0] i_pin,
  output logic [7:0] o_out,
  // Interrupt to the processor
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  srdio_st_t st; // Registered state
  srdio_st_t next_st; // Next state
  logic [5:0] widx; // Word index of the access
  logic [31:0] bm; // Byte lane mask from sel
  logic [31:0] wd; // Write data, lanes applied
  logic [31:0] rd; // Read data mux
  logic wr; // Write takes effect this edge
  logic w_eos; // End-of-scan command
  logic w_stop; // Program stop command
  logic w_run; // Program run command
  logic w_inrfs; // Input partial refresh
  logic w_outnow; // Immediate output write
  logic w_outrfs; // Output partial refresh
  logic [15:0] w_clr; // Interrupt status clear
  logic [12:0] hs_lim; // Fast group limit in ticks
  logic [12:0] st_lim; // Standard group limit in ticks
  logic [15:0] f_next; // Next filtered levels
  logic [15:0][12:0] c_next; // Next stability counts
  logic [15:0] hit; // Interrupt triggers this cycle
  logic [15:0] s_mid; // Status after clear
  logic [15:0] p_mid; // Pending after clear

  ////////////////////////////////////////////////////////////////////////
  // Filter limit lookup

  // Setting to ticks, rounded up so no setting is ever shortened
  function automatic logic [12:0] lim_ticks(input logic hs,
                                            input logic [2:0] sel);
    int us;
    us = 0;
    case (sel)
      3'h0: us = hs ? `SRDIO_HS_T0 : `SRDIO_ST_T0;
      3'h1: us = hs ? `SRDIO_HS_T1 : `SRDIO_ST_T1;
      3'h2: us = hs ? `SRDIO_HS_T2 : `SRDIO_ST_T2;
      3'h3: us = hs ? `SRDIO_HS_T3 : `SRDIO_ST_T3;
      3'h4: us = hs ? `SRDIO_HS_T4 : `SRDIO_ST_T4;
      // Unused codes fall to the longest, safest setting
      default: us = hs ? `SRDIO_HS_T5 : `SRDIO_ST_T5;
    endcase
    return 13'((us * 1000 + `SRDIO_TICK_NS - 1) / `SRDIO_TICK_NS);
  endfunction

  assign hs_lim = lim_ticks(1'b1, st.hs_sel); // [RQ6]
  assign st_lim = lim_ticks(1'b0, st.st_sel); // [RQ5]

  ////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Writes act at the edge where the master sees ack
  assign widx = i_wb.adr[7:2];
  assign bm = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}},
               {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};
  assign wd = i_wb.dat & bm;
  assign wr = st.ack & i_wb.cyc & i_wb.stb & i_wb.we;

  // Command strobes
  assign w_eos = wr && widx == `SRDIO_W_CMD && wd[`SRDIO_B_EOS];
  assign w_stop = wr && widx == `SRDIO_W_CMD && wd[`SRDIO_B_STOP];
  assign w_run = wr && widx == `SRDIO_W_CMD && wd[`SRDIO_B_RUN];
  assign w_inrfs = wr && widx == `SRDIO_W_IN_RFS;
  assign w_outnow = wr && widx == `SRDIO_W_OUT_NOW;
  assign w_outrfs = wr && widx == `SRDIO_W_OUT_RFS;
  assign w_clr = (wr && widx == `SRDIO_W_IRQ_STAT) ? wd[15:0] : 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Per-input filter and edge detect

  // One slice per input; group picks the limit
  for (genvar gi = 0; gi < `SRDIO_N_IN; gi++) begin : g_in
    logic cand; // Candidate level from synchroniser
    logic fire; // Candidate accepted this tick
    logic [12:0] lim; // Limit for this input
    // Fast group is the low six inputs [RQ1]
    assign lim = (gi < `SRDIO_HS_PINS) ? hs_lim : st_lim;
    // Change counts only when stages two and three agree
    assign cand = (st.s2[gi] == st.s3[gi]) ? st.s3[gi] : st.filt[gi];
    // Level must stay for the whole limit [RQ15]
    assign fire = st.tick && cand != st.filt[gi] &&
                  (st.cnt[gi] + 13'h0001) >= lim;
    assign c_next[gi] = (cand == st.filt[gi] || fire) ? 13'h0000 :
                        st.tick ? st.cnt[gi] + 13'h0001 : st.cnt[gi];
    assign f_next[gi] = fire ? cand : st.filt[gi];
    // Rise, fall or both by two trigger bits [RQ12] [RQ13]
    assign hit[gi] = st.irq_en[gi] &
                     ((st.trig[2*gi] & f_next[gi] & ~st.filt[gi]) |
                      (st.trig[2*gi+1] & ~f_next[gi] & st.filt[gi]));
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data

  // Unmapped words read as zero
  always_comb begin
    rd = 32'h0000_0000;
    case (widx)
      `SRDIO_W_CMD: begin
        rd[`SRDIO_B_EOS] = st.stopped;
      end
      `SRDIO_W_CFG: begin
        rd[`SRDIO_B_HOLD] = st.err_hold;
        rd[`SRDIO_F_HS] = st.hs_sel;
        rd[`SRDIO_F_ST] = st.st_sel;
      end
      `SRDIO_W_IN_IMG: rd[15:0] = st.in_img;
      // Live filtered pins, not the image [RQ3]
      `SRDIO_W_IN_NOW: rd[15:0] = st.filt;
      `SRDIO_W_OUT_IMG: rd[7:0] = st.out_img;
      `SRDIO_W_OUT_NOW: rd[7:0] = st.out_pin;
      `SRDIO_W_IRQ_EN: rd[15:0] = st.irq_en;
      `SRDIO_W_TRIG: rd = st.trig;
      `SRDIO_W_IRQ_STAT: rd = {st.pend, st.stat};
      `SRDIO_W_IRQ_MASK: rd[15:0] = st.mask;
      default: rd = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status after software clear

  // A clear with a pending trigger promotes it rather than losing it
  assign s_mid = st.stat & (~w_clr | st.pend);
  assign p_mid = st.pend & ~(st.stat & w_clr);

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    // Three-stage pin synchroniser
    next_st.s1 = i_pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // Filter tick prescaler
    if (st.tick_cnt == 9'(`SRDIO_TICK_CYC - 1)) begin
      next_st.tick_cnt = 9'h000;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 9'h001;
      next_st.tick = 1'b0;
    end
    next_st.filt = f_next; // [RQ5] [RQ6]
    next_st.cnt = c_next;

    // Bus answer one cycle after the request
    next_st.ack = i_wb.cyc & i_wb.stb & ~st.ack;
    next_st.dat = rd;

    // Plain register writes
    if (wr) begin
      case (widx)
        `SRDIO_W_CFG: begin
          if (i_wb.sel[0])
            next_st.err_hold = wd[`SRDIO_B_HOLD];
          if (i_wb.sel[0])
            next_st.hs_sel = wd[`SRDIO_F_HS];
          if (i_wb.sel[1])
            next_st.st_sel = wd[`SRDIO_F_ST];
        end
        `SRDIO_W_OUT_IMG: begin
          if (i_wb.sel[0])
            next_st.out_img = wd[7:0];
        end
        `SRDIO_W_IRQ_EN: begin
          next_st.irq_en = (st.irq_en & ~bm[15:0]) | wd[15:0]; // [RQ12]
        end
        `SRDIO_W_TRIG: begin
          next_st.trig = (st.trig & ~bm) | wd; // [RQ13]
        end
        `SRDIO_W_IRQ_MASK: begin
          next_st.mask = (st.mask & ~bm[15:0]) | wd[15:0];
        end
        default: begin
        end
      endcase
    end

    // Scan operations run only while the program runs
    if (!st.stopped) begin
      // End of scan refreshes the input image and the output pins
      if (w_eos) begin
        next_st.in_img = st.filt; // [RQ2]
        next_st.out_pin = st.out_img; // [RQ7] [RQ8]
      end
      // Partial input refresh of named bits
      if (w_inrfs) begin
        next_st.in_img = (st.in_img & ~wd[15:0]) | (st.filt & wd[15:0]); // [RQ4]
      end
      // Immediate output updates image and pin together
      if (w_outnow) begin
        next_st.out_img = (st.out_img & ~wd[`SRDIO_F_ONM]) |
                          (wd[`SRDIO_F_ONV] & wd[`SRDIO_F_ONM]); // [RQ9]
        next_st.out_pin = (st.out_pin & ~wd[`SRDIO_F_ONM]) |
                          (wd[`SRDIO_F_ONV] & wd[`SRDIO_F_ONM]); // [RQ9]
      end
      // Partial output refresh of named bits
      if (w_outrfs) begin
        next_st.out_pin = (st.out_pin & ~wd[7:0]) |
                          (st.out_img & wd[7:0]); // [RQ10]
      end
    end

    // Program stop: hold pins or clear them
    if (w_stop) begin
      next_st.stopped = 1'b1;
      if (!st.err_hold)
        next_st.out_pin = 8'h00; // [RQ11]
    end else if (w_run) begin
      next_st.stopped = 1'b0;
    end

    // Trigger sets status, else pends once, else drops [RQ14]
    next_st.stat = s_mid | hit;
    next_st.pend = p_mid | (hit & s_mid);
    // Level interrupt from unmasked status
    next_st.irq = |(st.stat & st.mask);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  // All state clears to zero: outputs off, filters idle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign o_wb_ack = st.ack;
  assign o_wb_dat = st.dat;
  assign o_out = st.out_pin;
  assign o_irq = st.irq;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // Input image moves only on end-of-scan or partial refresh
  a_in_img_scan: assert property ( // [RQ2]
    !w_eos && !w_inrfs |=> $stable(st.in_img))
    else $error("input image changed outside a refresh");

  // Output pins move only on a scan, direct, refresh or stop write
  a_out_pin_scan: assert property ( // [RQ8]
    !w_eos && !w_outnow && !w_outrfs && !w_stop |=> $stable(o_out))
    else $error("output pins changed without cause");

  // Clear mode drives outputs off right after the stop
  a_stop_clear: assert property ( // [RQ11]
    w_stop && !st.err_hold |=> o_out == 8'h00)
    else $error("outputs not cleared on program stop");

  // While stopped with no new command the pins stay put
  a_stop_hold: assert property ( // [RQ11]
    st.stopped && !w_run |=> $stable(o_out))
    else $error("outputs moved while stopped");

  // A pending trigger never exists without an active one
  a_pend_order: assert property ( // [RQ14]
    (st.pend & ~st.stat) == 16'h0000)
    else $error("pending trigger without active status");

  // Filtered level changes only toward a differing stable sample
  a_filt_cause: assert property ( // [RQ15]
    $changed(st.filt) |-> $past(st.tick) &&
      (($past(st.filt) ^ st.filt) & ~($past(st.s3) ^ st.filt)) ==
        ($past(st.filt) ^ st.filt))
    else $error("filtered level changed without cause");

  // Immediate write shows on the masked pins next cycle
  a_direct_out: assert property ( // [RQ9]
    w_outnow && !st.stopped && !w_stop |=>
      ((o_out ^ $past(wd[7:0])) & $past(wd[15:8])) == 8'h00)
    else $error("immediate output did not reach pins");

  // Partial input refresh copies live levels into named bits
  a_in_rfs: assert property ( // [RQ4]
    w_inrfs && !st.stopped |=>
      ((st.in_img ^ $past(st.filt)) & $past(wd[15:0])) == 16'h0000)
    else $error("partial input refresh wrong");

  // A trigger marks status at once and raises irq when unmasked
  a_trig_irq: assert property ( // [RQ12]
    |(hit & st.mask) |=> |st.stat ##1 o_irq)
    else $error("trigger did not raise interrupt");

  // Partial output refresh copies image bits onto named pins
  a_out_rfs: assert property ( // [RQ10]
    w_outrfs && !st.stopped |=>
      ((o_out ^ $past(st.out_img)) & $past(wd[7:0])) == 8'h00)
    else $error("partial output refresh wrong");

  // End of scan loads the whole input image from live levels
  a_eos_in: assert property ( // [RQ2]
    w_eos && !st.stopped |=> st.in_img == $past(st.filt))
    else $error("end-of-scan input refresh wrong");

  // Bus answers one cycle after the request and drops after
  a_wb_ack: assert property (
    i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("wishbone ack timing wrong");

endmodule // srdio_top

`default_nettype wire

// ===== testbench/srdio_field.sv
// Field-side model: switches and sensors on the inputs, lamps on outputs
`timescale 1ns/10ps
`default_nettype none

module srdio_field (
  // Clock for pacing pin changes
  input wire logic i_clk,
  // Lamp drive from the block
  input wire logic [7:0] i_out,
  // Switch and sensor levels to the block
  output var logic [15:0] o_pin
);
  logic [7:0] lamp; // Lamp state as a load would see it

  ////////////////////////////////////////////////////////////////////////////
  // Switches are wetted contacts: always a firm level, never floating
  initial begin
    o_pin = 16'h0000;
  end

  // Lamps simply follow their drive line
  always_ff @(posedge i_clk) begin
    lamp <= i_out;
  end

  // Set every switch level just after an edge
  task automatic set_pins(input logic [15:0] v);
    @(posedge i_clk);
    o_pin <= v;
  endtask

  // Contact bounce: one input flips briefly, then returns
  task automatic glitch(input int idx, input int width);
    @(posedge i_clk);
    o_pin[idx] <= ~o_pin[idx];
    repeat (width) @(posedge i_clk);
    o_pin[idx] <= ~o_pin[idx];
  endtask
endmodule // srdio_field

`default_nettype wire

// ===== testbench/srdio_top_test.sv
// Self-checking bench of the scan-refreshed discrete I/O block
`timescale 1ns/10ps
`default_nettype none
`include "srdio_regs.svh"

// Compare two values, count it, report a mismatch at once
`define CHK(what, exp, got) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
  end \
end

module srdio_top_test
  import srdio_pkg::*;
();
  logic i_clk = 1'b0; // Bench clock, 40 MHz
  logic i_rst_b; // Async reset, active low
  srdio_wb_t wb; // Wishbone request lines
  logic [3:0] bsel; // Byte lanes of the next access
  logic o_wb_ack; // Bus answer
  logic [31:0] o_wb_dat; // Read data
  logic [15:0] pins; // Field input levels
  logic [7:0] o_out; // Lamp drive
  logic o_irq; // Interrupt line
  int miscompares; // Mismatches seen
  int cmp_count; // Comparisons made

  ////////////////////////////////////////////////////////////////////////////
  // Design and the field around it
  srdio_top dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_wb(wb),
    .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .i_pin(pins),
    .o_out(o_out), .o_irq(o_irq));
  srdio_field field (.i_clk(i_clk), .i_out(o_out), .o_pin(pins));

  // Free-running clock, 25 ns period
  always begin
    #12.5 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run, shared by the main flow and bus timeouts
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One classic cycle; held until ack is sampled, bounded wait
  task automatic bus(input logic we, input logic [5:0] w,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    wb <= '{cyc:1'b1, stb:1'b1, we:we, adr:{w, 2'b00}, sel:bsel, dat:d};
    do begin
      @(posedge i_clk);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 16);
    q = o_wb_dat;
    wb <= '0;
    // A slave that never answers ends the run
    if (o_wb_ack !== 1'b1) begin
      miscompares++;
      print_verdict();
    end
  endtask

  // Register write
  task automatic wr(input logic [5:0] w, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, w, d, q);
  endtask

  // Register read against an expected word
  task automatic rd(input logic [5:0] w, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, w, 32'h0000_0000, q);
    `CHK("read data", exp, q)
  endtask

  // Let pending pin or image updates land before sampling
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    bsel = 4'hf;
    i_rst_b = 1'b0;
    wb = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;

    // Outputs: image, end-of-scan, immediate, partial, stop modes
    wr(`SRDIO_W_OUT_IMG, 32'h0000_005a);
    idle(3);
    `CHK("o_out", 8'h00, o_out)
    wr(`SRDIO_W_CMD, 32'h0000_0001);
    idle(2);
    `CHK("o_out", 8'h5a, o_out)
    `CHK("lamp", 8'h5a, field.lamp)
    wr(`SRDIO_W_OUT_NOW, 32'h0000_0f03);
    idle(2);
    `CHK("o_out", 8'h53, o_out)
    wr(`SRDIO_W_OUT_IMG, 32'h0000_00ff);
    wr(`SRDIO_W_OUT_RFS, 32'h0000_0081);
    idle(2);
    `CHK("o_out", 8'hd3, o_out)
    // Clear mode: stop drops every lamp, scans are then ignored
    wr(`SRDIO_W_CMD, 32'h0000_0002);
    wr(`SRDIO_W_CMD, 32'h0000_0001);
    idle(2);
    `CHK("o_out", 8'h00, o_out)
    rd(`SRDIO_W_CMD, 32'h0000_0001);
    wr(`SRDIO_W_CMD, 32'h0000_0004);
    wr(`SRDIO_W_CMD, 32'h0000_0001);
    // Hold mode: stop keeps the last lamp state
    wr(`SRDIO_W_CFG, 32'h0000_0001);
    wr(`SRDIO_W_CMD, 32'h0000_0002);
    idle(2);
    `CHK("o_out", 8'hff, o_out)
    wr(`SRDIO_W_CMD, 32'h0000_0004);
    rd(6'h3f, 32'h0000_0000);
    $display("Test outputs done");

    // Inputs: fastest settings, one fast pin and one standard pin
    wr(`SRDIO_W_CFG, 32'h0000_0000);
    field.set_pins(16'h0041);
    idle(300);
    rd(`SRDIO_W_IN_NOW, 32'h0000_0000);
    idle(700);
    rd(`SRDIO_W_IN_NOW, 32'h0000_0001);
    idle(4000);
    rd(`SRDIO_W_IN_NOW, 32'h0000_0041);
    rd(`SRDIO_W_IN_IMG, 32'h0000_0000);
    wr(`SRDIO_W_IN_RFS, 32'h0000_0040);
    rd(`SRDIO_W_IN_IMG, 32'h0000_0040);
    wr(`SRDIO_W_CMD, 32'h0000_0001);
    rd(`SRDIO_W_IN_IMG, 32'h0000_0041);
    // Short bounce on a standard pin must not pass the filter
    field.glitch(7, 100);
    field.set_pins(16'h0040);
    idle(1000);
    rd(`SRDIO_W_IN_NOW, 32'h0000_0040);
    rd(`SRDIO_W_IN_IMG, 32'h0000_0041);
    $display("Test inputs done");

    // Interrupt on input 0, both edges, masked first
    wr(`SRDIO_W_IRQ_EN, 32'h0000_0001);
    wr(`SRDIO_W_TRIG, 32'h0000_0003);
    wr(`SRDIO_W_IRQ_MASK, 32'h0000_0000);
    field.set_pins(16'h0041);
    idle(1000);
    `CHK("o_irq", 1'b0, o_irq)
    rd(`SRDIO_W_IRQ_STAT, 32'h0000_0001);
    wr(`SRDIO_W_IRQ_MASK, 32'h0000_0001);
    idle(2);
    `CHK("o_irq", 1'b1, o_irq)
    // Fall pends, next rise is dropped
    field.set_pins(16'h0040);
    idle(1000);
    field.set_pins(16'h0041);
    idle(1000);
    rd(`SRDIO_W_IRQ_STAT, 32'h0001_0001);
    wr(`SRDIO_W_IRQ_STAT, 32'h0000_0001);
    rd(`SRDIO_W_IRQ_STAT, 32'h0000_0001);
    wr(`SRDIO_W_IRQ_STAT, 32'h0000_0001);
    idle(2);
    `CHK("o_irq", 1'b0, o_irq)
    // Rise-only ignores a fall; fall-only ignores a rise
    wr(`SRDIO_W_TRIG, 32'h0000_0001);
    field.set_pins(16'h0040);
    idle(1000);
    rd(`SRDIO_W_IRQ_STAT, 32'h0000_0000);
    wr(`SRDIO_W_TRIG, 32'h0000_0002);
    field.set_pins(16'h0041);
    idle(1000);
    rd(`SRDIO_W_IRQ_STAT, 32'h0000_0000);
    field.set_pins(16'h0040);
    idle(1000);
    rd(`SRDIO_W_IRQ_STAT, 32'h0000_0001);
    $display("Test interrupts done");

    // Byte lanes: only the low lane of the config word lands
    bsel = 4'h1;
    wr(`SRDIO_W_CFG, 32'h0000_0511);
    bsel = 4'hf;
    rd(`SRDIO_W_CFG, 32'h0000_0011);
    // Second fast setting: ten ticks of stability before a change
    field.set_pins(16'h0044);
    idle(2000);
    rd(`SRDIO_W_IN_NOW, 32'h0000_0040);
    idle(2500);
    rd(`SRDIO_W_IN_NOW, 32'h0000_0044);
    // Upper lanes only of the trigger word
    bsel = 4'hc;
    wr(`SRDIO_W_TRIG, 32'hffff_ffff);
    bsel = 4'hf;
    rd(`SRDIO_W_TRIG, 32'hffff_0002);
    $display("Test lanes done");
    print_verdict();
  end
endmodule // srdio_top_test

`default_nettype wire
